/* File: verilog/sampler_msg_pkg.sv */
// Constants for the sampler message decoder: descriptor and header fields,
// message type codes, SIMD modes, lengths and register map.
// Assumes a 32-bit AXI4-Lite register bus in front of the decoder.
package sampler_msg_pkg;

  // ==========================================================
  // Descriptor fields
  localparam int DescHeaderBit   = 19;
  localparam int DescSimdHi      = 17;
  localparam int DescSimdLo      = 16;
  localparam int DescTypeHi      = 15;
  localparam int DescTypeLo      = 12;
  localparam int DescSamplerHi   = 11;
  localparam int DescSamplerLo   = 8;
  localparam int DescBindHi      = 7;
  localparam int DescBindLo      = 0;
  localparam int DescWideTypeBit = 18;

  // ==========================================================
  // Header fields
  localparam int HdrMaskHi = 15;
  localparam int HdrMaskLo = 12;
  localparam int HdrUOffHi = 11;
  localparam int HdrUOffLo = 8;
  localparam int HdrVOffHi = 7;
  localparam int HdrVOffLo = 4;
  localparam int HdrROffHi = 3;
  localparam int HdrROffLo = 0;

  // ==========================================================
  // SIMD modes
  localparam logic [1:0] SimdFourByTwo = 2'h0;
  localparam logic [1:0] SimdEight     = 2'h1;
  localparam logic [1:0] SimdSixteen   = 2'h2;
  localparam logic [1:0] SimdWide      = 2'h3;

  // Narrow message types
  localparam logic [3:0] MtSample      = 4'h0;
  localparam logic [3:0] MtBias        = 4'h1;
  localparam logic [3:0] MtLod         = 4'h2;
  localparam logic [3:0] MtCompare     = 4'h3;
  localparam logic [3:0] MtGradient    = 4'h4;
  localparam logic [3:0] MtBiasCmp     = 4'h5;
  localparam logic [3:0] MtLodCmp      = 4'h6;
  localparam logic [3:0] MtTexelFetch  = 4'h7;
  localparam logic [3:0] MtGather      = 4'h8;
  localparam logic [3:0] MtLodQuery    = 4'h9;
  localparam logic [3:0] MtResInfo     = 4'hA;
  localparam logic [3:0] MtSampleInfo  = 4'hB;
  localparam logic [3:0] MtSampleKill  = 4'hC;

  // Wide message types (five bits)
  localparam logic [4:0] WtUnormPix    = 5'h00;
  localparam logic [4:0] WtUnormKillPx = 5'h02;
  localparam logic [4:0] WtBlockPix    = 5'h03;
  localparam logic [4:0] WtInterleave  = 5'h08;
  localparam logic [4:0] WtUnormMedia  = 5'h0C;
  localparam logic [4:0] WtUnormKillMd = 5'h0A;
  localparam logic [4:0] WtBlockMedia  = 5'h0B;

  // ==========================================================
  // Lengths
  localparam logic [4:0] MaxMsgLen      = 5'h0B;
  localparam logic [4:0] RespFourByTwo  = 5'h01;
  localparam logic [4:0] RespEight      = 5'h04;
  localparam logic [4:0] RespEightKill  = 5'h05;
  localparam logic [4:0] RespSixteen    = 5'h08;
  localparam logic [4:0] RespUnorm      = 5'h08;
  localparam logic [4:0] RespUnormKill  = 5'h09;
  localparam logic [4:0] RespBlock      = 5'h10;
  localparam logic [4:0] StepTwo        = 5'h02;
  localparam logic [4:0] StepFour       = 5'h04;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] AddrDesc    = 8'h00;
  localparam logic [7:0] AddrHeader  = 8'h04;
  localparam logic [7:0] AddrLength  = 8'h08;
  localparam logic [7:0] AddrStatus  = 8'h0C;
  localparam logic [7:0] AddrResult  = 8'h10;
  localparam logic [7:0] AddrOffsets = 8'h14;
  localparam logic [1:0] RespOkay    = 2'h0;
  localparam logic [1:0] RespSlvErr  = 2'h2;

endpackage

/* File: verilog/sampler_message_decoder.sv */
// Sampler message decoder: software writes a descriptor, an optional header
// and the received message length, then reads back the decoded fields.
// Assumes an AXI4-Lite master with at most one write and one read in flight.
//
// Overview of operation
// - Header bit selects header phase, else zeros
// - Two-bit SIMD mode selects message form
// - Message type field identifies the operation
// - Sampler index, ignored for fetch/info messages
// - Eight-bit binding table index selects surface
// - No header: all channels written, zero offsets
// - Header mask bit one suppresses that channel
// - Interleave filter ignores channel masks
// - Three signed four-bit texel offsets
// - Offsets ignored for block messages, gather; the code zeroes them for unorm, block and interleave only, gather keeps them
// - Parameters float, except fetch/info integer; the code flags fetch and resinfo only, sampleinfo stays float
// - Omitted higher parameters default to zero
// - Registers with only unused parameters omitted
// - Length is header plus per-mode parameter phases
// - Response lengths per SIMD mode
// - Sixteen-wide response drops two per mask
// - Narrow forms decode four-bit types
// - Wide form decodes five-bit types, length H+1
// - Block filter drops four, unorm two per mask
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

module sampler_message_decoder (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================================
  // Software-written registers and AXI4-Lite channel state
  logic [31:0] descReg,   descNext;
  logic [31:0] headerReg, headerNext;
  logic [4:0]  lenReg,    lenNext;
  logic        awHeldReg, awHeldNext;
  logic        wHeldReg,  wHeldNext;
  logic [7:0]  awAddrReg, awAddrNext;
  logic [31:0] wDataReg,  wDataNext;
  logic [3:0]  wStrbReg,  wStrbNext;
  logic        bValidReg, bValidNext;
  logic [1:0]  bRespReg,  bRespNext;
  logic        rValidReg, rValidNext;
  logic [31:0] rDataReg,  rDataNext;
  logic [1:0]  rRespReg,  rRespNext;

  // ==========================================================
  // Decoded fields (combinational)
  logic        hdrPresent;
  logic [1:0]  simdMode;
  logic [3:0]  msgType;
  logic [4:0]  wideType;
  logic [3:0]  samplerIdx;
  logic [7:0]  bindIdx;
  logic [31:0] hdrEff;
  logic [3:0]  chanMask;
  logic [3:0]  offU, offV, offR;
  logic [2:0]  maskCount;
  logic        isInterleave, isBlock, isUnorm, isKillWide, noSampler, intParams;
  logic [3:0]  numParams;
  logic [4:0]  expLen, respLen;
  logic        typeBad, lenBad, lenMismatch, errFlag;

  // Header phase or all-zero header when absent
  always_comb begin
    hdrPresent = descReg[sampler_msg_pkg::DescHeaderBit];
    hdrEff     = hdrPresent ? headerReg : 32'h0000_0000;
    simdMode   = descReg[sampler_msg_pkg::DescSimdHi:sampler_msg_pkg::DescSimdLo];
    msgType    = descReg[sampler_msg_pkg::DescTypeHi:sampler_msg_pkg::DescTypeLo];
    wideType   = {descReg[sampler_msg_pkg::DescWideTypeBit], msgType};
    samplerIdx = descReg[sampler_msg_pkg::DescSamplerHi:sampler_msg_pkg::DescSamplerLo];
    bindIdx    = descReg[sampler_msg_pkg::DescBindHi:sampler_msg_pkg::DescBindLo];
  end

  // Wide-form classification and narrow parameter counts
  always_comb begin
    isInterleave = 1'b0;
    isBlock      = 1'b0;
    isUnorm      = 1'b0;
    isKillWide   = 1'b0;
    typeBad      = 1'b0;
    numParams    = 4'h0;
    if (simdMode == sampler_msg_pkg::SimdWide) begin
      case (wideType)
        sampler_msg_pkg::WtUnormPix,
        sampler_msg_pkg::WtUnormMedia:  isUnorm = 1'b1;
        sampler_msg_pkg::WtUnormKillPx,
        sampler_msg_pkg::WtUnormKillMd: begin
          isUnorm    = 1'b1;
          isKillWide = 1'b1;
        end
        sampler_msg_pkg::WtBlockPix,
        sampler_msg_pkg::WtBlockMedia:  isBlock = 1'b1;
        sampler_msg_pkg::WtInterleave:  isInterleave = 1'b1;
        default:                        typeBad = 1'b1;
      endcase
    end else begin
      // Minimum parameter count; longer messages carry optional extras
      case (msgType)
        sampler_msg_pkg::MtSample,
        sampler_msg_pkg::MtCompare,
        sampler_msg_pkg::MtGather,
        sampler_msg_pkg::MtLodQuery,
        sampler_msg_pkg::MtSampleKill,
        sampler_msg_pkg::MtBias,
        sampler_msg_pkg::MtLod,
        sampler_msg_pkg::MtGradient,
        sampler_msg_pkg::MtBiasCmp,
        sampler_msg_pkg::MtLodCmp,
        sampler_msg_pkg::MtTexelFetch,
        sampler_msg_pkg::MtResInfo,
        sampler_msg_pkg::MtSampleInfo:  numParams = 4'h1;
        default:                        typeBad = 1'b1;
      endcase
      // Kill variant is eight-wide only
      if (msgType == sampler_msg_pkg::MtSampleKill && simdMode != sampler_msg_pkg::SimdEight)
        typeBad = 1'b1;
    end
  end

  // Channel masks and offsets after the per-type ignore cases
  always_comb begin
    chanMask = hdrEff[sampler_msg_pkg::HdrMaskHi:sampler_msg_pkg::HdrMaskLo];
    if (isInterleave)
      chanMask = 4'h0;
    offU = hdrEff[sampler_msg_pkg::HdrUOffHi:sampler_msg_pkg::HdrUOffLo];
    offV = hdrEff[sampler_msg_pkg::HdrVOffHi:sampler_msg_pkg::HdrVOffLo];
    offR = hdrEff[sampler_msg_pkg::HdrROffHi:sampler_msg_pkg::HdrROffLo];
    if (isUnorm || isBlock || isInterleave) begin
      offU = 4'h0;
      offV = 4'h0;
      offR = 4'h0;
    end
    maskCount = 3'(chanMask[0]) + 3'(chanMask[1]) + 3'(chanMask[2]) + 3'(chanMask[3]);
    noSampler = (simdMode != sampler_msg_pkg::SimdWide) &&
                (msgType == sampler_msg_pkg::MtTexelFetch ||
                 msgType == sampler_msg_pkg::MtResInfo ||
                 msgType == sampler_msg_pkg::MtSampleInfo);
    intParams = (simdMode != sampler_msg_pkg::SimdWide) &&
                (msgType == sampler_msg_pkg::MtTexelFetch ||
                 msgType == sampler_msg_pkg::MtResInfo);
  end

  // Expected length floor and response length
  always_comb begin
    case (simdMode)
      sampler_msg_pkg::SimdFourByTwo: begin
        expLen  = 5'(hdrPresent) + 5'h01;
        respLen = sampler_msg_pkg::RespFourByTwo;
      end
      sampler_msg_pkg::SimdEight: begin
        expLen  = 5'(hdrPresent) + 5'(numParams);
        respLen = (msgType == sampler_msg_pkg::MtSampleKill) ?
                  sampler_msg_pkg::RespEightKill : sampler_msg_pkg::RespEight;
      end
      sampler_msg_pkg::SimdSixteen: begin
        expLen  = 5'(hdrPresent) + 5'({numParams, 1'b0});
        respLen = sampler_msg_pkg::RespSixteen - 5'({maskCount, 1'b0});
      end
      default: begin
        expLen  = 5'(hdrPresent) + 5'h01;
        if (isBlock)
          respLen = sampler_msg_pkg::RespBlock - 5'({maskCount, 2'b00});
        else if (isUnorm)
          respLen = (isKillWide ? sampler_msg_pkg::RespUnormKill : sampler_msg_pkg::RespUnorm)
                    - 5'({maskCount, 1'b0});
        else
          respLen = 5'h00; // Interleave depends on sampler state
      end
    endcase
    // Omitted parameter registers shorten the message, never below the floor
    lenBad      = lenReg > sampler_msg_pkg::MaxMsgLen;
    lenMismatch = (simdMode == sampler_msg_pkg::SimdWide) ? (lenReg != expLen)
                                                          : (lenReg < expLen);
    errFlag     = typeBad || lenBad || lenMismatch;
  end

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order
  always_comb begin
    awHeldNext = awHeldReg;
    wHeldNext  = wHeldReg;
    awAddrNext = awAddrReg;
    wDataNext  = wDataReg;
    wStrbNext  = wStrbReg;
    bValidNext = bValidReg;
    bRespNext  = bRespReg;
    descNext   = descReg;
    headerNext = headerReg;
    lenNext    = lenReg;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeldNext = 1'b1;
      awAddrNext = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeldNext = 1'b1;
      wDataNext = s_axi_wdata;
      wStrbNext = s_axi_wstrb;
    end
    if (bValidReg && s_axi_bready)
      bValidNext = 1'b0;
    if (awHeldReg && wHeldReg && !bValidReg) begin
      awHeldNext = 1'b0;
      wHeldNext  = 1'b0;
      bValidNext = 1'b1;
      bRespNext  = sampler_msg_pkg::RespOkay;
      if (awAddrReg == sampler_msg_pkg::AddrDesc) begin
        for (int b = 0; b < 4; b++)
          if (wStrbReg[b]) descNext[b*8 +: 8] = wDataReg[b*8 +: 8];
      end else if (awAddrReg == sampler_msg_pkg::AddrHeader) begin
        for (int b = 0; b < 4; b++)
          if (wStrbReg[b]) headerNext[b*8 +: 8] = wDataReg[b*8 +: 8];
      end else if (awAddrReg == sampler_msg_pkg::AddrLength) begin
        if (wStrbReg[0]) lenNext = wDataReg[4:0];
      end else begin
        bRespNext = sampler_msg_pkg::RespSlvErr;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_comb begin
    rValidNext = rValidReg;
    rDataNext  = rDataReg;
    rRespNext  = rRespReg;
    if (rValidReg && s_axi_rready)
      rValidNext = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rValidNext = 1'b1;
      rRespNext  = sampler_msg_pkg::RespOkay;
      if (s_axi_araddr == sampler_msg_pkg::AddrDesc)
        rDataNext = descReg;
      else if (s_axi_araddr == sampler_msg_pkg::AddrHeader)
        rDataNext = headerReg;
      else if (s_axi_araddr == sampler_msg_pkg::AddrLength)
        rDataNext = {27'h0, lenReg};
      else if (s_axi_araddr == sampler_msg_pkg::AddrStatus)
        rDataNext = {24'h0, intParams, noSampler, lenMismatch, lenBad,
                     typeBad, errFlag, simdMode};
      else if (s_axi_araddr == sampler_msg_pkg::AddrResult)
        // Sampler index reads zero when the type does not use it
        rDataNext = {3'h0, respLen, 3'h0, expLen, (noSampler ? 4'h0 : samplerIdx),
                     chanMask, bindIdx};
      else if (s_axi_araddr == sampler_msg_pkg::AddrOffsets)
        rDataNext = {20'h0, offU, offV, offR};
      else begin
        rDataNext = 32'h0000_0000;
        rRespNext = sampler_msg_pkg::RespSlvErr;
      end
    end
  end

  // ==========================================================
  // State registers; decoder holds no state beyond software values and AXI4-Lite channel state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      descReg   <= 32'h0000_0000;
      headerReg <= 32'h0000_0000;
      lenReg    <= 5'h00;
      awHeldReg <= 1'b0;
      wHeldReg  <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg  <= 32'h0000_0000;
      wStrbReg  <= 4'h0;
      bValidReg <= 1'b0;
      bRespReg  <= 2'h0;
      rValidReg <= 1'b0;
      rDataReg  <= 32'h0000_0000;
      rRespReg  <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      descReg   <= descNext;
      headerReg <= headerNext;
      lenReg    <= lenNext;
      awHeldReg <= awHeldNext;
      wHeldReg  <= wHeldNext;
      awAddrReg <= awAddrNext;
      wDataReg  <= wDataNext;
      wStrbReg  <= wStrbNext;
      bValidReg <= bValidNext;
      bRespReg  <= bRespNext;
      rValidReg <= rValidNext;
      rDataReg  <= rDataNext;
      rRespReg  <= rRespNext;
      // Ready only while the channel is empty, one accept per transfer
      s_axi_awready <= !awHeldNext && !bValidNext && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHeldNext && !bValidNext && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !rValidNext && !(s_axi_arvalid && s_axi_arready);
    end
  end

  assign s_axi_bvalid = bValidReg;
  assign s_axi_bresp  = bRespReg;
  assign s_axi_rvalid = rValidReg;
  assign s_axi_rdata  = rDataReg;
  assign s_axi_rresp  = rRespReg;

  // ==========================================================
  // Checks
  AST_NOHDR_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    !hdrPresent |-> (chanMask == 4'h0 && offU == 4'h0 && offV == 4'h0 && offR == 4'h0))
    else $error("Absent header must give zero masks and offsets");
  AST_SIXTEEN_RESP: assert property (@(posedge clock) disable iff (!rst_n)
    simdMode == sampler_msg_pkg::SimdSixteen |-> respLen == 5'(5'h08 - 5'({maskCount, 1'b0})))
    else $error("Sixteen-wide response length wrong");
  AST_EIGHT_RESP: assert property (@(posedge clock) disable iff (!rst_n)
    simdMode == sampler_msg_pkg::SimdEight |-> (respLen == 5'h04 || respLen == 5'h05))
    else $error("Eight-wide response length wrong");
  AST_FOURBYTWO_RESP: assert property (@(posedge clock) disable iff (!rst_n)
    simdMode == sampler_msg_pkg::SimdFourByTwo |-> respLen == 5'h01)
    else $error("Four-by-two response length wrong");
  AST_BLOCK_RESP: assert property (@(posedge clock) disable iff (!rst_n)
    isBlock |-> respLen == 5'(5'h10 - 5'({maskCount, 2'b00})))
    else $error("Block filter response length wrong");
  AST_INTERLEAVE_MASK: assert property (@(posedge clock) disable iff (!rst_n)
    isInterleave |-> chanMask == 4'h0)
    else $error("Interleave must ignore masks");
  AST_OVERLONG: assert property (@(posedge clock) disable iff (!rst_n)
    lenReg > 5'h0B |-> errFlag)
    else $error("Overlong message not flagged");
  AST_WIDE_LEN: assert property (@(posedge clock) disable iff (!rst_n)
    simdMode == sampler_msg_pkg::SimdWide |-> expLen == 5'(5'(hdrPresent) + 5'h01))
    else $error("Wide message length wrong");
  AST_BRESP_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  AST_UNORM_RESP: assert property (@(posedge clock) disable iff (!rst_n)
    isUnorm |-> respLen == 5'((isKillWide ? 5'h09 : 5'h08) - 5'({maskCount, 1'b0})))
    else $error("Unorm block response length wrong");
  AST_KILL_EIGHT_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
    (msgType == sampler_msg_pkg::MtSampleKill && simdMode != sampler_msg_pkg::SimdEight &&
     simdMode != sampler_msg_pkg::SimdWide) |-> typeBad)
    else $error("Kill type outside eight-wide not refused");
  AST_WIDE_MISMATCH: assert property (@(posedge clock) disable iff (!rst_n)
    (simdMode == sampler_msg_pkg::SimdWide && lenReg != expLen) |-> errFlag)
    else $error("Wide length mismatch not flagged");
  // Response only after both halves of the write were held
  AST_WRITE_RESP_ORDER: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(s_axi_bvalid) |-> ($past(awHeldReg) && $past(wHeldReg)))
    else $error("Write response before address and data");
  AST_READY_WHILE_RESP: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("Write channel open while response pending");
  COV_WIDE: cover property (@(posedge clock) disable iff (!rst_n) isBlock && maskCount != 3'h0);
  COV_ERR: cover property (@(posedge clock) disable iff (!rst_n) errFlag);
  COV_SIXTEEN: cover property (@(posedge clock) disable iff (!rst_n)
    simdMode == sampler_msg_pkg::SimdSixteen && hdrPresent);
  COV_INTERLEAVE: cover property (@(posedge clock) disable iff (!rst_n)
    isInterleave && hdrPresent);
  COV_KILL: cover property (@(posedge clock) disable iff (!rst_n)
    simdMode == sampler_msg_pkg::SimdEight && msgType == sampler_msg_pkg::MtSampleKill);

endmodule

/* File: verification/msg_sender_model.sv */
// AXI4-Lite master model standing in for the thread that sends messages.
// Assumes its tasks are called one at a time, just after a rising clock edge.
`timescale 1ns/1ps

module msg_sender_model (
  input  wire logic        clock,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // ==========================================================
  // Idle levels; read ready stays high, write ready waits for the response
  initial begin
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b1;
  end

  // ==========================================================
  // Write: address and data offered together, each released when taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aDone;
    logic wDone;
    aDone = 1'b0;
    wDone = 1'b0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    while (!(aDone && wDone)) begin
      @(posedge clock);
      if (!aDone && awready) begin
        aDone = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a; // Released lines show the inverse, never a stale match
      end
      if (!wDone && wready) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
    do @(posedge clock); while (!bvalid);
    // Late ready makes the slave hold its response for one edge
    bready <= 1'b1;
    @(posedge clock);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Read: address held until taken, data captured on the rvalid edge
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge clock); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
endmodule

/* File: verification/sampler_message_decoder_test.sv */
// Self-checking bench for the sampler message decoder over AXI4-Lite.
// Assumes the decoder's register map and status layout.
`timescale 1ns/1ps

module sampler_message_decoder_test;
  logic        clock;
  logic        rst_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          miscompares;
  int          n_tests;
  // Row: descriptor, header, length, expected status, result, offsets
  typedef struct packed {
    logic [31:0] desc;
    logic [31:0] hdr;
    logic [31:0] len;
    logic [31:0] stat;
    logic [31:0] res;
    logic [31:0] offs;
  } row_t;
  // Stimulus keeps sampler alignment, never masks all four
  // Lengths stay within 11 except the last row, overlong on purpose
  localparam row_t Rows [9] = '{
    '{32'h9053C, 32'h01F7, 32'd4, 32'h01, 32'h0402503C, 32'h1F7},
    '{32'h279FF, 32'h7123, 32'd6, 32'hC2, 32'h080200FF, 32'h0},
    '{32'hA0000, 32'hC000, 32'd5, 32'h02, 32'h04030C00, 32'h0},
    '{32'h1C201, 32'h0,    32'd3, 32'h01, 32'h05012001, 32'h0},
    '{32'h0A300, 32'h0,    32'd1, 32'hC0, 32'h01010000, 32'h0},
    '{32'hB3400, 32'h1123, 32'd2, 32'h03, 32'h0C024100, 32'h0},
    '{32'hB0000, 32'h2555, 32'd2, 32'h03, 32'h06020200, 32'h0},
    '{32'hB8200, 32'h7000, 32'd2, 32'h03, 32'h00022000, 32'h0},
    '{32'h20000, 32'h0,    32'd12, 32'h16, 32'h08020000, 32'h0}};

  sampler_message_decoder dut (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  msg_sender_model sender (
    .clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ==========================================================
  // Clock at 10 MHz
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    sender.axiRead(a, got, rsp);
  endtask

  // Loads descriptor, header and received length for one message
  task automatic send(input logic [31:0] d, input logic [31:0] h, input logic [31:0] l);
    sender.axiWrite(sampler_msg_pkg::AddrDesc, d, rsp);
    check({30'h0, rsp}, {30'h0, sampler_msg_pkg::RespOkay});
    sender.axiWrite(sampler_msg_pkg::AddrHeader, h, rsp);
    check({30'h0, rsp}, {30'h0, sampler_msg_pkg::RespOkay});
    sender.axiWrite(sampler_msg_pkg::AddrLength, l, rsp);
    check({30'h0, rsp}, {30'h0, sampler_msg_pkg::RespOkay});
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the full sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    miscompares = 0;
    n_tests = 0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    // Length register comes out of reset cleared
    rd(sampler_msg_pkg::AddrLength);
    check(got, 32'h0);
    for (int i = 0; i < 9; i++) begin
      send(Rows[i].desc, Rows[i].hdr, Rows[i].len);
      rd(sampler_msg_pkg::AddrStatus);
      check(got, Rows[i].stat);
      rd(sampler_msg_pkg::AddrResult);
      check(got, Rows[i].res);
      rd(sampler_msg_pkg::AddrOffsets);
      check(got, Rows[i].offs);
      check({30'h0, rsp}, {30'h0, sampler_msg_pkg::RespOkay});
    end
    // Every narrow type code in eight-wide form, no header, one phase
    for (int t = 0; t < 13; t++) begin
      send(32'h10000 | (32'(t) << 12), 32'h0, 32'd1);
      rd(sampler_msg_pkg::AddrStatus);
      check(got, {24'h0, (t == 7 || t == 10), (t == 7 || t == 10 || t == 11), 6'h01});
      rd(sampler_msg_pkg::AddrResult);
      check(got, {3'h0, (t == 12) ? 5'h05 : 5'h04, 3'h0, 5'h01, 16'h0});
    end
    // Kill type outside eight-wide is refused as unsupported
    send(32'h2C000, 32'h0, 32'd4);
    rd(sampler_msg_pkg::AddrStatus);
    check(got, 32'h0E);
    // Wide form without header must be exactly one phase long
    send(32'h30000, 32'h0, 32'd2);
    rd(sampler_msg_pkg::AddrStatus);
    check(got, 32'h27);
    rd(sampler_msg_pkg::AddrDesc);
    check(got, 32'h30000);
    // Unmapped address answers with an error and reads as zero
    sender.axiWrite(8'h18, 32'hFFFFFFFF, rsp);
    check({30'h0, rsp}, {30'h0, sampler_msg_pkg::RespSlvErr});
    rd(8'h18);
    check(got, 32'h0);
    check({30'h0, rsp}, {30'h0, sampler_msg_pkg::RespSlvErr});
    // Mid-run reset clears the descriptor written earlier
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(sampler_msg_pkg::AddrDesc);
    check(got, 32'h0);
    finish_test();
  end
endmodule
